// *** bench/rs485_driver_enable_control_tb.sv ***
// Self-checking bench for the RS485 driver-enable control block
`timescale 1ns/10ps
module rs485_driver_enable_control_tb;
  localparam int MS = 10;
  logic        clk, rst_n, read, write, rxInValid, sw, stall;
  logic [7:0]  address, rxInData, txData;
  logic [31:0] writedata, readdata, rd;
  logic        waitrequest, txValid, txReady, txBusy, deOut, rs485Active, consoleAllowed;
  int          errorCnt, nTests, cyc, t0, n;

  rs485_driver_enable_control #(.MS_CYCLES(MS)) rs485_driver_enable_control_inst (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .byteenable(4'hF), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .txValid(txValid), .txData(txData), .txReady(txReady),
    .txBusy(txBusy), .rxInValid(rxInValid), .rxInData(rxInData), .interfaceSelectSwitch(sw),
    .deOut(deOut), .rs485Active(rs485Active), .consoleAllowed(consoleAllowed));
  uart_line_model uart_line_model_inst (.clk(clk), .rst_n(rst_n), .stall(stall), .txValid(txValid),
    .txData(txData), .txReady(txReady), .txBusy(txBusy));

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // Cuts a hang short; the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errorCnt++;
      testDone();
    end
  end

  task automatic testDone;
    $display("errors %0d tests %0d", errorCnt, nTests);
    if (errorCnt == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic reset_with(input logic s);
    rst_n <= 1'b0;
    sw <= s;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic rx(input logic [7:0] b);
    @(posedge clk);
    rxInValid <= 1'b1;
    rxInData <= b;
    @(posedge clk);
    rxInValid <= 1'b0;
  endtask
  task automatic wait_de(input logic v);
    while (deOut !== v) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    bus(0, rs485_de_pkg::CFG_OFFS, 0);
    check(rd, 32'h0000_0003);
    bus(0, rs485_de_pkg::PRE_OFFS, 0);
    check(rd, 32'h0000_0000);
    bus(0, rs485_de_pkg::POST_OFFS, 0);
    check(rd, 32'h0000_0000);
    bus(0, 8'h20, 0);
    check(rd, 32'h0000_0000);
    check(rs485Active, 1);
    check(consoleAllowed, 0);
    check(deOut, 0);
  endtask
  task automatic t_delays;
    bus(1, rs485_de_pkg::CFG_OFFS, 32'h0000_0003);
    bus(1, rs485_de_pkg::PRE_OFFS, 32'h0000_0002);
    bus(1, rs485_de_pkg::POST_OFFS, 32'h0000_0001);
    bus(1, rs485_de_pkg::TXDATA_OFFS, 32'h0000_00A5);
    wait_de(1);
    t0 = cyc;
    rx(8'h3C);
    while (txValid !== 1'b1) @(posedge clk);
    check(32'(cyc - t0 >= 2 * MS && cyc - t0 <= 2 * MS + 3), 1);
    check(deOut, 1);
    while (txBusy !== 1'b0 || txValid !== 1'b0) @(posedge clk);
    t0 = cyc;
    wait_de(0);
    check(32'(cyc - t0 >= MS && cyc - t0 <= MS + 4), 1);
    check(uart_line_model_inst.got.pop_front(), 8'hA5);
    bus(0, rs485_de_pkg::RXDATA_OFFS, 0);
    check(rd[8], 0);
    rx(8'h5A);
    bus(0, rs485_de_pkg::RXDATA_OFFS, 0);
    check(rd, 32'h0000_015A);
  endtask
  task automatic t_full_duplex;
    bus(1, rs485_de_pkg::CFG_OFFS, 32'h0000_0013);
    bus(1, rs485_de_pkg::TXDATA_OFFS, 32'h0000_0011);
    wait_de(1);
    rx(8'h77);
    bus(0, rs485_de_pkg::RXDATA_OFFS, 0);
    check(rd, 32'h0000_0177);
    wait_de(0);
    check(uart_line_model_inst.got.pop_front(), 8'h11);
  endtask
  task automatic t_levels;
    bus(1, rs485_de_pkg::CFG_OFFS, 32'h0000_0005);
    repeat (3) @(posedge clk);
    check(deOut, 1);
    bus(1, rs485_de_pkg::TXDATA_OFFS, 32'h0000_0022);
    while (txValid !== 1'b1) @(posedge clk);
    check(deOut, 0);
    while (txBusy !== 1'b0 || txValid !== 1'b0) @(posedge clk);
    repeat (2 * MS) @(posedge clk);
    check(deOut, 1);
    check(uart_line_model_inst.got.pop_front(), 8'h22);
    // Option word with the enable bit clear: plain port, driver enable stays low
    bus(1, rs485_de_pkg::CFG_OFFS, 32'h0000_0002);
    repeat (2) @(posedge clk);
    check(rs485Active, 0);
    check(consoleAllowed, 1);
    bus(1, rs485_de_pkg::TXDATA_OFFS, 32'h0000_0033);
    while (txValid !== 1'b1) @(posedge clk);
    check(deOut, 0);
    while (txBusy !== 1'b0 || txValid !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
    check(uart_line_model_inst.got.pop_front(), 8'h33);
    bus(1, rs485_de_pkg::CFG_OFFS, 32'h0000_0003);
  endtask
  task automatic t_fifo;
    stall <= 1'b1;
    n = 0;
    do begin
      bus(1, rs485_de_pkg::TXDATA_OFFS, 32'(n));
      n++;
      bus(0, rs485_de_pkg::STATUS_OFFS, 0);
    end while (rd[6] !== 1'b1 && n < 12);
    check(32'(n >= 8 && n <= 9), 1);
    check(rd[5], 1);
    stall <= 1'b0;
    while (uart_line_model_inst.got.size() < n) @(posedge clk);
    for (int i = 0; i < n; i++) check(uart_line_model_inst.got.pop_front(), 8'(i));
    wait_de(0);
  endtask
  task automatic t_switch_on;
    reset_with(1'b1);
    check(rs485Active, 0);
    check(consoleAllowed, 1);
    check(deOut, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 0;
    read = 0;
    write = 0;
    address = 0;
    writedata = 0;
    rxInValid = 0;
    rxInData = 0;
    sw = 0;
    stall = 0;
    reset_with(1'b0);
    t_reset();
    t_delays();
    t_full_duplex();
    t_levels();
    t_fifo();
    t_switch_on();
    testDone();
  end
endmodule // rs485_driver_enable_control_tb

// *** bench/uart_line_model.sv ***
// Behavioural UART beyond the transmit stream, taking bytes and shifting them out
`timescale 1ns/10ps
module uart_line_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       stall,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  output logic            txBusy
);
  logic [7:0] got[$];
  int         left;
  // Each byte keeps txBusy up for a while, so the block must not end sending early
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= 0;
      txReady <= 1'b0;
      txBusy <= 1'b0;
    end else begin
      txBusy <= (txValid && txReady) || left > 1;
      if (txValid && txReady) begin
        got.push_back(txData);
        left <= 6;
        txReady <= 1'b0;
      end else begin
        if (left > 0) left <= left - 1;
        txReady <= !stall && left <= 1;
      end
    end
  end
endmodule // uart_line_model

// *** hdl/rs485_de_pkg.sv ***
// Constants and types shared by the RS485 driver-enable control block
package rs485_de_pkg;
  localparam logic [7:0]  CFG_OFFS       = 8'h00;
  localparam logic [7:0]  PRE_OFFS       = 8'h04;
  localparam logic [7:0]  POST_OFFS      = 8'h08;
  localparam logic [7:0]  TXDATA_OFFS    = 8'h0C;
  localparam logic [7:0]  RXDATA_OFFS    = 8'h10;
  localparam logic [7:0]  STATUS_OFFS    = 8'h14;
  localparam int          EN_BIT         = 0;
  localparam int          ON_SEND_BIT    = 1;
  localparam int          AFTER_SEND_BIT = 2;
  localparam int          FULL_DUP_BIT   = 4;
  localparam int          RXVALID_BIT    = 8;
  localparam logic [7:0]  CFG_RESET      = 8'h03;
  localparam logic [7:0]  CFG_MASK       = 8'h17;
  localparam logic [15:0] DELAY_RESET    = 16'h0000;
  localparam int          MS_TIME_NS     = 1000000;
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          MS_CYCLES      = MS_TIME_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  SYNC_SETTLE    = 2'h2;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          DATA_W         = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE  = 2'b01,
    ST_SEND = 2'b10,
    ST_POST = 2'b11
  } de_state_t;
endpackage

// *** hdl/rs485_driver_enable_control.sv ***
// RS485 driver-enable sequencer with Avalon-MM registers and transmit FIFO
`timescale 1ns/10ps

module rs485_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wrPtr;
    logic [AW:0]                 rdPtr;
  } fifo_state_t;
  fifo_state_t st_ff;
  fifo_state_t nxt_st;
  logic        full;
  logic        empty;

  assign empty    = st_ff.wrPtr == st_ff.rdPtr;
  assign full     = (st_ff.wrPtr[AW-1:0] == st_ff.rdPtr[AW-1:0]) && (st_ff.wrPtr[AW] != st_ff.rdPtr[AW]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = st_ff.mem[st_ff.rdPtr[AW-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (inValid && !full) begin
      nxt_st.mem[st_ff.wrPtr[AW-1:0]] = inData;
      nxt_st.wrPtr = st_ff.wrPtr + 1'b1;
    end
    if (outReady && !empty) begin
      nxt_st.rdPtr = st_ff.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // rs485_tx_fifo

////////////////////////////////////////////////////////////////////////////////

// What this block does
// - Line options are one word: bit0 enable, bits1-2 DE levels, bit4 duplex.
// - Outside sending, DE equals the idle-level option; default low.
// - Receive-while-sending option set gives full duplex; 0x13 is an example.
// - Wait the pre-send delay in milliseconds after raising DE; default zero.
// - Hold DE in sending state for the post-send delay in ms; default zero.
// - Interface switch OFF at power-up brings RS485 up active with defaults.
// - An RS485-active port is never usable as the system console.
module rs485_driver_enable_control #(
  parameter int MS_CYCLES = rs485_de_pkg::MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             txValid,
  output logic [7:0]       txData,
  input  wire logic        txReady,
  input  wire logic        txBusy,
  input  wire logic        rxInValid,
  input  wire logic [7:0]  rxInData,
  input  wire logic        interfaceSelectSwitch,
  output logic             deOut,
  output logic             rs485Active,
  output logic             consoleAllowed
);
  typedef struct packed {
    rs485_de_pkg::de_state_t state;
    logic [7:0]              cfg;
    logic [15:0]             preDelay;
    logic [15:0]             postDelay;
    logic                    waitReq;
    logic [31:0]             rdData;
    logic [17:0]             tickCnt;
    logic [15:0]             msCnt;
    logic                    txValid;
    logic [7:0]              txData;
    logic                    rxValid;
    logic [7:0]              rxData;
    logic                    de;
    logic                    active;
    logic                    console;
    logic                    swMeta;
    logic                    swSync;
    logic [1:0]              settle;
    logic                    swDone;
    logic                    swOn;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;
  logic       fifoInReady;
  logic       fifoOutValid;
  logic [7:0] fifoOutData;
  logic       fifoPop;
  logic       wrTxData;
  logic       accept;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Delay reached once the whole-ms count meets the programmed value
  function automatic logic msDone(input logic [15:0] cnt, input logic [15:0] lim);
    msDone = cnt >= lim;
  endfunction

  // A full FIFO holds off the bus, so the master stalls instead of losing bytes
  assign accept   = write && !st_ff.waitReq;
  assign wrTxData = accept && address == rs485_de_pkg::TXDATA_OFFS && byteenable[0];

  rs485_tx_fifo #(
    .WIDTH (rs485_de_pkg::DATA_W),
    .DEPTH (rs485_de_pkg::FIFO_DEPTH)
  ) rs485_tx_fifo_inst (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (wrTxData),
    .inReady  (fifoInReady),
    .inData   (writedata[7:0]),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  assign fifoPop = st_ff.state == rs485_de_pkg::ST_SEND && (!st_ff.txValid || txReady);

  always_comb begin
    nxt_st = st_ff;
    // Switch passes two flops before the capture reads it
    nxt_st.swMeta = interfaceSelectSwitch;
    nxt_st.swSync = st_ff.swMeta;
    if (st_ff.settle != rs485_de_pkg::SYNC_SETTLE) begin
      nxt_st.settle = st_ff.settle + 2'h1;
    end else if (!st_ff.swDone) begin
      nxt_st.swDone = 1'b1;
      nxt_st.swOn   = st_ff.swSync;
    end

    // Bus: one wait cycle, more while a TXDATA write finds the FIFO full, then waitrequest low for exactly the taking edge
    nxt_st.waitReq = 1'b1;
    if ((read || write) && st_ff.waitReq && !(write && address == rs485_de_pkg::TXDATA_OFFS && !fifoInReady)) begin
      nxt_st.waitReq = 1'b0;
      unique case (address)
        rs485_de_pkg::CFG_OFFS:    nxt_st.rdData = {24'h00_0000, st_ff.cfg};
        rs485_de_pkg::PRE_OFFS:    nxt_st.rdData = {16'h0000, st_ff.preDelay};
        rs485_de_pkg::POST_OFFS:   nxt_st.rdData = {16'h0000, st_ff.postDelay};
        rs485_de_pkg::RXDATA_OFFS: nxt_st.rdData = {23'h00_0000, st_ff.rxValid, st_ff.rxData};
        rs485_de_pkg::STATUS_OFFS: nxt_st.rdData = {25'h00_0000, !fifoInReady, fifoOutValid,
                                                    st_ff.console, st_ff.active, st_ff.state, st_ff.de};
        default:                   nxt_st.rdData = 32'h0000_0000;
      endcase
    end
    if (accept && address == rs485_de_pkg::CFG_OFFS && byteenable[0]) begin
      nxt_st.cfg = writedata[7:0] & rs485_de_pkg::CFG_MASK;
    end
    if (accept && address == rs485_de_pkg::PRE_OFFS) begin
      nxt_st.preDelay = merge16(st_ff.preDelay, writedata, byteenable);
    end
    if (accept && address == rs485_de_pkg::POST_OFFS) begin
      nxt_st.postDelay = merge16(st_ff.postDelay, writedata, byteenable);
    end
    if (read && !st_ff.waitReq && address == rs485_de_pkg::RXDATA_OFFS) begin
      nxt_st.rxValid = 1'b0;
    end
    // Received byte dropped in half duplex while DE is in sending state; set wins over the read clear
    if (rxInValid && (st_ff.cfg[rs485_de_pkg::FULL_DUP_BIT] || !st_ff.active
        || st_ff.state == rs485_de_pkg::ST_IDLE)) begin
      nxt_st.rxValid = 1'b1;
      nxt_st.rxData  = rxInData;
    end

    // Millisecond timebase, restarted on each state change
    if (st_ff.tickCnt == 18'(MS_CYCLES - 1)) begin
      nxt_st.tickCnt = 18'h0_0000;
      nxt_st.msCnt   = (st_ff.msCnt == 16'hFFFF) ? st_ff.msCnt : st_ff.msCnt + 16'h0001;
    end else begin
      nxt_st.tickCnt = st_ff.tickCnt + 18'h0_0001;
    end

    if (fifoPop) begin
      nxt_st.txValid = fifoOutValid;
      nxt_st.txData  = fifoOutData;
    end
    // Delays apply only with RS485 active; a plain port sends at once
    unique case (st_ff.state)
      rs485_de_pkg::ST_IDLE: begin
        if (fifoOutValid) begin
          nxt_st.state = rs485_de_pkg::ST_PRE;
        end
      end
      rs485_de_pkg::ST_PRE: begin
        if (!st_ff.active || msDone(st_ff.msCnt, st_ff.preDelay)) begin
          nxt_st.state = rs485_de_pkg::ST_SEND;
        end
      end
      rs485_de_pkg::ST_SEND: begin
        // Busy rises only after the UART takes a byte, so the held txValid must be low as well as txBusy
        if (!fifoOutValid && !st_ff.txValid && !txBusy) begin
          nxt_st.state = rs485_de_pkg::ST_POST;
        end
      end
      rs485_de_pkg::ST_POST: begin
        if (fifoOutValid) begin
          nxt_st.state = rs485_de_pkg::ST_SEND;
        end else if (!st_ff.active || msDone(st_ff.msCnt, st_ff.postDelay)) begin
          nxt_st.state = rs485_de_pkg::ST_IDLE;
        end
      end
    endcase
    if (nxt_st.state != st_ff.state) begin
      nxt_st.tickCnt = 18'h0_0000;
      nxt_st.msCnt   = 16'h0000;
    end

    nxt_st.active  = nxt_st.cfg[rs485_de_pkg::EN_BIT] && nxt_st.swDone && !nxt_st.swOn;
    nxt_st.console = !nxt_st.active;
    if (!nxt_st.active) begin
      nxt_st.de = 1'b0;
    end else if (nxt_st.state == rs485_de_pkg::ST_IDLE) begin
      nxt_st.de = nxt_st.cfg[rs485_de_pkg::AFTER_SEND_BIT];
    end else begin
      nxt_st.de = nxt_st.cfg[rs485_de_pkg::ON_SEND_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff           <= '0;
      st_ff.state     <= rs485_de_pkg::ST_IDLE;
      st_ff.cfg       <= rs485_de_pkg::CFG_RESET;
      st_ff.preDelay  <= rs485_de_pkg::DELAY_RESET;
      st_ff.postDelay <= rs485_de_pkg::DELAY_RESET;
      st_ff.waitReq   <= 1'b1;
      st_ff.console   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign readdata       = st_ff.rdData;
  assign waitrequest    = st_ff.waitReq;
  assign txValid        = st_ff.txValid;
  assign txData         = st_ff.txData;
  assign deOut          = st_ff.de;
  assign rs485Active    = st_ff.active;
  assign consoleAllowed = st_ff.console;

  ////////////////////////////////////////////////////////////////////////////////

  a_cfg_write: assert property (@(posedge clk) disable iff (!rst_n)
    accept && address == rs485_de_pkg::CFG_OFFS && byteenable[0]
    |=> st_ff.cfg == ($past(writedata[7:0]) & rs485_de_pkg::CFG_MASK))
    else $error("Option word not stored");
  a_de_sending: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.active && st_ff.state == rs485_de_pkg::ST_SEND |-> deOut == st_ff.cfg[rs485_de_pkg::ON_SEND_BIT])
    else $error("DE wrong while sending");
  a_de_idle: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.active && st_ff.state == rs485_de_pkg::ST_IDLE |-> deOut == st_ff.cfg[rs485_de_pkg::AFTER_SEND_BIT])
    else $error("DE wrong while idle");
  a_rx_full_dup: assert property (@(posedge clk) disable iff (!rst_n)
    rxInValid && st_ff.cfg[rs485_de_pkg::FULL_DUP_BIT] |=> st_ff.rxValid && st_ff.rxData == $past(rxInData))
    else $error("Full duplex byte lost");
  a_pre_wait: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.active && st_ff.state == rs485_de_pkg::ST_PRE && st_ff.msCnt < st_ff.preDelay
    |=> st_ff.state != rs485_de_pkg::ST_SEND)
    else $error("Sending began before pre delay");
  a_post_hold: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.active && st_ff.state == rs485_de_pkg::ST_POST && st_ff.msCnt < st_ff.postDelay
    |=> st_ff.state != rs485_de_pkg::ST_IDLE)
    else $error("DE released before post delay");
  a_switch_off: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.swDone && !st_ff.swOn |-> rs485Active == st_ff.cfg[rs485_de_pkg::EN_BIT])
    else $error("RS485 not active with switch off");
  a_no_console: assert property (@(posedge clk) disable iff (!rst_n)
    rs485Active |-> !consoleAllowed)
    else $error("Console allowed with RS485 active");
  a_echo_block: assert property (@(posedge clk) disable iff (!rst_n)
    rxInValid && st_ff.active && !st_ff.cfg[rs485_de_pkg::FULL_DUP_BIT] && st_ff.state != rs485_de_pkg::ST_IDLE
    |=> $stable(st_ff.rxData))
    else $error("Own echo received in half duplex");
endmodule // rs485_driver_enable_control
